//--- hw/test_packet_generator.sv
`timescale 1ns/10ps
module test_packet_generator #(
   parameter int DATA_BYTES = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rdata_valid,
   // streaming source
   output tpg_pkg::tx_word_t tx_word,
   output logic tx_valid,
   input wire logic tx_ready
);

   typedef enum logic [1:0] {ST_IDLE, ST_BEGIN, ST_SEND, ST_LAST} gen_state_t;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_meta_n;
   logic rst_sync_n;
   // async assert, clean release through two stages
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [31:0] packet_quota, src_mac_low, dst_mac_low, sent_frame_counter;
   logic [31:0] prbs_seed_low, prbs_seed_mid, prbs_seed_high;
   logic [15:0] frame_config, src_mac_high, dst_mac_high;
   logic run_request, run_halt, run_done;
   logic start_take, frame_accept, quota_reached;
   gen_state_t state;

   function automatic logic wr_hit(input logic [5:0] ofs);
      wr_hit = reg_write && (reg_addr == ofs);
   endfunction : wr_hit

   // plain software-owned settings
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         packet_quota <= tpg_pkg::RST_REG;
         frame_config <= tpg_pkg::RST_REG[15:0];
         src_mac_low <= tpg_pkg::RST_REG;
         src_mac_high <= tpg_pkg::RST_REG[15:0];
         dst_mac_low <= tpg_pkg::RST_REG;
         dst_mac_high <= tpg_pkg::RST_REG[15:0];
         prbs_seed_low <= tpg_pkg::RST_REG;
         prbs_seed_mid <= tpg_pkg::RST_REG;
         prbs_seed_high <= tpg_pkg::RST_REG;
      end else begin
         if (wr_hit(tpg_pkg::OFS_PACKET_QUOTA)) packet_quota <= reg_wdata;
         if (wr_hit(tpg_pkg::OFS_FRAME_CONFIG)) frame_config <= reg_wdata[15:0];
         if (wr_hit(tpg_pkg::OFS_SRC_MAC_LOW)) src_mac_low <= reg_wdata;
         if (wr_hit(tpg_pkg::OFS_SRC_MAC_HIGH)) src_mac_high <= reg_wdata[15:0];
         if (wr_hit(tpg_pkg::OFS_DST_MAC_LOW)) dst_mac_low <= reg_wdata;
         if (wr_hit(tpg_pkg::OFS_DST_MAC_HIGH)) dst_mac_high <= reg_wdata[15:0];
         if (wr_hit(tpg_pkg::OFS_PRBS_SEED_LOW)) prbs_seed_low <= reg_wdata;
         if (wr_hit(tpg_pkg::OFS_PRBS_SEED_MID)) prbs_seed_mid <= reg_wdata;
         if (wr_hit(tpg_pkg::OFS_PRBS_SEED_HIGH)) prbs_seed_high <= reg_wdata;
      end
   end

   // run control: a fresh request write wins over the self-clear
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         run_request <= 1'b0;
         run_halt <= 1'b0;
      end else begin
         if (wr_hit(tpg_pkg::OFS_RUN_CONTROL) && reg_wdata[tpg_pkg::RUN_REQUEST_BIT]) begin
            run_request <= 1'b1;
         end else if (start_take) begin
            run_request <= 1'b0;
         end
         if (wr_hit(tpg_pkg::OFS_RUN_CONTROL) && reg_wdata[tpg_pkg::RUN_HALT_BIT]) begin
            run_halt <= 1'b1;
         end else if (start_take) begin
            run_halt <= 1'b0;
         end
      end
   end

   // readback, one cycle after the read strobe; holes read zero
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= tpg_pkg::RST_REG;
         reg_rdata_valid <= 1'b0;
      end else begin
         reg_rdata_valid <= reg_read;
         if (reg_read) begin
            case (reg_addr)
               tpg_pkg::OFS_PACKET_QUOTA: reg_rdata <= packet_quota;
               tpg_pkg::OFS_FRAME_CONFIG: reg_rdata <= {16'h0000, frame_config};
               tpg_pkg::OFS_RUN_CONTROL: reg_rdata <= {29'h0, run_done, run_halt, run_request};
               tpg_pkg::OFS_SRC_MAC_LOW: reg_rdata <= src_mac_low;
               tpg_pkg::OFS_SRC_MAC_HIGH: reg_rdata <= {16'h0000, src_mac_high};
               tpg_pkg::OFS_DST_MAC_LOW: reg_rdata <= dst_mac_low;
               tpg_pkg::OFS_DST_MAC_HIGH: reg_rdata <= {16'h0000, dst_mac_high};
               tpg_pkg::OFS_SENT_FRAME_COUNTER: reg_rdata <= sent_frame_counter;
               tpg_pkg::OFS_PRBS_SEED_LOW: reg_rdata <= prbs_seed_low;
               tpg_pkg::OFS_PRBS_SEED_MID: reg_rdata <= prbs_seed_mid;
               tpg_pkg::OFS_PRBS_SEED_HIGH: reg_rdata <= prbs_seed_high;
               default: reg_rdata <= tpg_pkg::RST_REG;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // length and payload generators
   // ---------------------------------------------------------------
   logic [15:0] len_lfsr;
   logic [91:0] prbs;
   logic [10:0] len_draw;
   logic [13:0] frame_len, eff_len;
   logic [15:0] word_idx, seq_num;
   logic word_load;

   // free-running so each frame sees a fresh draw
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         len_lfsr <= tpg_pkg::RST_LEN_LFSR;
      end else begin
         len_lfsr <= {len_lfsr[14:0], len_lfsr[15] ^ len_lfsr[13] ^ len_lfsr[12] ^ len_lfsr[10]};
      end
   end

   // fold 0..2047 onto 0..1494 so length lands in 24..1518
   assign len_draw = (len_lfsr[10:0] >= tpg_pkg::LEN_RAND_SPAN) ?
                     len_lfsr[10:0] - tpg_pkg::LEN_RAND_SPAN : len_lfsr[10:0];

   // 64 shifts of the 92-bit register per word; all-zero seed stays stuck
   function automatic logic [91:0] prbs_step(input logic [91:0] s);
      logic [91:0] t;
      t = s;
      for (int i = 0; i < 64; i++) begin
         t = {t[90:0], t[91] ^ t[90] ^ t[79] ^ t[78]};
      end
      prbs_step = t;
   endfunction : prbs_step

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prbs <= 92'h0;
      end else if (start_take && frame_config[tpg_pkg::CFG_PATTERN_PRBS_BIT]) begin
         prbs <= {prbs_seed_high[27:0], prbs_seed_mid, prbs_seed_low};
      end else if (word_load) begin
         prbs <= prbs_step(prbs);
      end
   end

   // byte at frame position idx: dst, src, length, sequence, payload, pad
   function automatic logic [7:0] frame_byte(input logic [15:0] idx);
      logic [47:0] dst;
      logic [47:0] src;
      logic [15:0] pay;
      dst = {dst_mac_high, dst_mac_low};
      src = {src_mac_high, src_mac_low};
      pay = idx - tpg_pkg::PAYLOAD_POS;
      if (idx < 16'd6) frame_byte = dst[8'(47 - 8 * idx[2:0]) -: 8];
      else if (idx < 16'd12) frame_byte = src[8'(47 - 8 * (idx[3:0] - 4'd6)) -: 8];
      else if (idx == 16'd12) frame_byte = {2'b00, frame_len[13:8]};
      else if (idx == 16'd13) frame_byte = frame_len[7:0];
      else if (idx == tpg_pkg::HDR_SEQ_POS) frame_byte = seq_num[15:8];
      else if (idx == tpg_pkg::HDR_SEQ_POS + 16'd1) frame_byte = seq_num[7:0];
      else if (idx >= {2'b00, frame_len}) frame_byte = 8'h00; // zero pad to 64
      else if (frame_config[tpg_pkg::CFG_PATTERN_PRBS_BIT])
         frame_byte = prbs[8'(63 - 8 * pay[2:0]) -: 8];
      else frame_byte = pay[7:0];
   endfunction : frame_byte

   // ---------------------------------------------------------------
   // generator state machine and streaming source
   // ---------------------------------------------------------------
   logic [15:0] word_count;
   logic [2:0] last_empty;
   logic [63:0] next_data;

   assign start_take = run_request;
   assign eff_len = (frame_len < tpg_pkg::LEN_PAD_MIN) ? tpg_pkg::LEN_PAD_MIN : frame_len;
   assign word_count = 16'((eff_len + 14'd7) >> 3);
   assign last_empty = 3'(14'(word_count[12:0] * 8) - eff_len);
   // a word is loaded when the output slot is free or being drained
   assign word_load = (state == ST_SEND) && (!tx_valid || tx_ready);
   assign frame_accept = tx_valid && tx_ready && tx_word.eop;
   assign quota_reached = (sent_frame_counter + 32'd1) >= packet_quota;

   always_comb begin
      next_data = 64'h0;
      for (int b = 0; b < DATA_BYTES; b++) begin
         next_data[8 * (7 - b) +: 8] = frame_byte(16'({word_idx[12:0], 3'b000} + b));
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= ST_IDLE;
         frame_len <= tpg_pkg::LEN_MIN;
         word_idx <= 16'h0000;
         seq_num <= 16'h0000;
         sent_frame_counter <= tpg_pkg::RST_REG;
         run_done <= 1'b0;
      end else if (start_take) begin
         // restart from any state; any frame in flight is abandoned
         sent_frame_counter <= tpg_pkg::RST_REG;
         seq_num <= 16'h0000;
         state <= (packet_quota == 32'h0) ? ST_IDLE : ST_BEGIN;
         run_done <= (packet_quota == 32'h0);
      end else begin
         case (state)
            ST_IDLE: state <= ST_IDLE;
            ST_BEGIN: begin
               word_idx <= 16'h0000;
               if (frame_config[tpg_pkg::CFG_LENGTH_RANDOM_BIT]) begin
                  frame_len <= tpg_pkg::LEN_MIN + {3'b000, len_draw};
               end else begin
                  frame_len <= frame_config[tpg_pkg::CFG_LENGTH_MSB:tpg_pkg::CFG_LENGTH_LSB];
               end
               state <= ST_SEND;
            end
            ST_SEND: begin
               if (word_load) begin
                  word_idx <= word_idx + 16'd1;
                  if (word_idx + 16'd1 == word_count) state <= ST_LAST;
               end
            end
            ST_LAST: begin
               if (frame_accept) begin
                  sent_frame_counter <= sent_frame_counter + 32'd1;
                  seq_num <= seq_num + 16'd1;
                  if (quota_reached) begin
                     run_done <= 1'b1;
                     state <= ST_IDLE;
                  end else if (run_halt) begin
                     state <= ST_IDLE;
                  end else begin
                     state <= ST_BEGIN;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // output register; holds until the sink takes it or a start request drops it
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_valid <= 1'b0;
         tx_word <= '0;
      end else if (start_take) begin
         tx_valid <= 1'b0;
      end else if (word_load) begin
         tx_valid <= 1'b1;
         tx_word.data <= next_data;
         tx_word.sop <= (word_idx == 16'h0000);
         tx_word.eop <= (word_idx + 16'd1 == word_count);
         tx_word.empty <= (word_idx + 16'd1 == word_count) ? last_empty : 3'h0;
      end else if (tx_ready) begin
         tx_valid <= 1'b0;
      end
   end

endmodule : test_packet_generator

//--- hw/tpg_pkg.sv
package tpg_pkg;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [5:0] OFS_PACKET_QUOTA = 6'h00;
   localparam logic [5:0] OFS_FRAME_CONFIG = 6'h04;
   localparam logic [5:0] OFS_RUN_CONTROL = 6'h08;
   localparam logic [5:0] OFS_SRC_MAC_LOW = 6'h10;
   localparam logic [5:0] OFS_SRC_MAC_HIGH = 6'h14;
   localparam logic [5:0] OFS_DST_MAC_LOW = 6'h18;
   localparam logic [5:0] OFS_DST_MAC_HIGH = 6'h1C;
   localparam logic [5:0] OFS_SENT_FRAME_COUNTER = 6'h24;
   localparam logic [5:0] OFS_PRBS_SEED_LOW = 6'h30;
   localparam logic [5:0] OFS_PRBS_SEED_MID = 6'h34;
   localparam logic [5:0] OFS_PRBS_SEED_HIGH = 6'h38;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CFG_LENGTH_RANDOM_BIT = 0;
   localparam int CFG_LENGTH_LSB = 1;
   localparam int CFG_LENGTH_MSB = 14;
   localparam int CFG_PATTERN_PRBS_BIT = 15;
   localparam int RUN_REQUEST_BIT = 0;
   localparam int RUN_HALT_BIT = 1;
   localparam int RUN_DONE_BIT = 2;

   // ---------------------------------------------------------------
   // reset values and frame geometry
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_REG = 32'h0000_0000;
   localparam logic [15:0] RST_LEN_LFSR = 16'hACE1;
   localparam logic [13:0] LEN_MIN = 14'h0018;
   localparam logic [13:0] LEN_PAD_MIN = 14'h0040;
   localparam logic [10:0] LEN_RAND_SPAN = 11'h5D7;
   localparam logic [15:0] HDR_SEQ_POS = 16'h000E;
   localparam logic [15:0] PAYLOAD_POS = 16'h0010;

   // one word on the streaming source
   typedef struct packed {
      logic [63:0] data;
      logic sop;
      logic eop;
      logic [2:0] empty;
   } tx_word_t;

endpackage : tpg_pkg

//--- test/test_packet_generator_tb.sv
`timescale 1ns/10ps
module test_packet_generator_tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [31:0] reg_rdata;
   logic reg_rdata_valid;
   tpg_pkg::tx_word_t tx_word;
   logic tx_valid;
   logic tx_ready;
   logic slow = 1'b0;
   logic [7:0] fb [0:127];
   int flen;
   int frames;
   int err_total = 0;
   int tests_run = 0;
   logic [31:0] v;
   logic [31:0] w;
   logic [5:0] offs [0:11] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h24,
      6'h30, 6'h34, 6'h38, 6'h0C};
   logic [5:0] wa [0:4] = '{6'h00, 6'h04, 6'h14, 6'h1C, 6'h24};
   logic [31:0] we [0:4] = '{32'hFFFF_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
      32'h0000_0000};
   always #10 clk_sys = ~clk_sys;
   test_packet_generator #(.DATA_BYTES(8)) dut_u (.clk_sys, .rst_n, .reg_addr, .reg_write,
      .reg_read, .reg_wdata, .reg_rdata, .reg_rdata_valid, .tx_word, .tx_valid, .tx_ready);
   tpg_sink_model sink_u (.clk_sys, .tx_word, .tx_valid, .tx_ready, .slow, .fb, .flen, .frames);
   task wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask : wr
   // answer stands in the cycle after the read edge; taken at the edge that samples valid
   task rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
      if (reg_rdata_valid !== 1'b1) begin
         err_total++;
         $display("MISMATCH %0t read answer missing", $time);
      end
   endtask : rd
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // polls the done flag; a hang shows up in the later status compare
   task run(input logic [31:0] q, input logic [15:0] cfg);
      logic [31:0] s;
      s = 32'h0000_0000;
      wr(6'h00, q);
      wr(6'h04, {16'h0000, cfg});
      wr(6'h08, 32'h0000_0001);
      for (int i = 0; i < 600 && s[2] !== 1'b1; i++) begin
         rd(6'h08, s);
      end
   endtask : run
   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   // watchdog sized well above the longest expected run
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 12; i++) begin
         rd(offs[i], v);
         chk(v, 32'h0000_0000);
      end
      for (int i = 0; i < 5; i++) begin
         wr(wa[i], 32'hFFFF_FFFF);
         rd(wa[i], v);
         chk(v, we[i]);
      end
      wr(6'h1C, 32'h0000_A1B2);
      wr(6'h18, 32'hC3D4_E5F6);
      wr(6'h14, 32'h0000_1122);
      wr(6'h10, 32'h3344_5566);
      slow <= 1'b1;
      run(32'h0000_0002, 16'h0086);
      chk(32'(flen), 32'h0000_0043);
      chk(32'(frames), 32'h0000_0002);
      chk({fb[0], fb[5], fb[6], fb[11]}, 32'hA1F6_1166);
      chk({fb[12], fb[13], fb[14], fb[15]}, 32'h0043_0001);
      chk({8'h00, fb[16], fb[17], fb[66]}, 32'h0000_0132);
      rd(6'h24, v);
      chk(v, 32'h0000_0002);
      rd(6'h08, v);
      chk(v, 32'h0000_0004);
      slow <= 1'b0;
      run(32'h0000_0001, 16'h0030);
      chk(32'(flen), 32'h0000_0040);
      chk({fb[12], fb[13], fb[23], fb[24]}, 32'h0018_0700);
      run(32'h0000_0003, 16'h0001);
      v = {16'h0000, fb[12], fb[13]};
      chk(32'(v >= 32'h18 && v <= 32'h5EE), 32'h0000_0001);
      chk(32'(flen), (v < 32'h40) ? 32'h0000_0040 : v);
      run(32'h0000_0001, 16'h8080);
      chk({fb[16], fb[40], fb[63], 8'h00}, 32'h0000_0000);
      wr(6'h30, 32'h0000_0001);
      run(32'h0000_0001, 16'h8080);
      w = 32'h0000_0000;
      for (int k = 16; k < 64; k++) w = w | {24'h0, fb[k]};
      chk(32'(w != 32'h0), 32'h0000_0001);
      wr(6'h00, 32'h0000_03E8);
      wr(6'h04, 32'h0000_0080);
      wr(6'h08, 32'h0000_0001);
      repeat (60) @(posedge clk_sys);
      wr(6'h08, 32'h0000_0002);
      repeat (100) @(posedge clk_sys);
      rd(6'h24, v);
      repeat (50) @(posedge clk_sys);
      rd(6'h24, w);
      chk(w, v);
      rd(6'h08, v);
      chk(v, 32'h0000_0002);
      wr(6'h00, 32'h0000_0000);
      wr(6'h08, 32'h0000_0001);
      repeat (4) @(posedge clk_sys);
      rd(6'h08, v);
      chk(v, 32'h0000_0004);
      rd(6'h24, v);
      chk(v, 32'h0000_0000);
      finish_test();
   end
endmodule : test_packet_generator_tb

//--- test/tpg_checker.sv
`timescale 1ns/10ps
// ---------------------------------------------
// port checker for the test frame generator
// ---------------------------------------------
module tpg_checker #(
   parameter int DATA_BYTES = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [5:0] reg_addr,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rdata_valid,
   input wire tpg_pkg::tx_word_t tx_word,
   input wire logic tx_valid,
   input wire logic tx_ready
);
   logic [31:0] eop_seen;
   logic start_wr;
   logic take;
   assign start_wr = reg_write && reg_addr == tpg_pkg::OFS_RUN_CONTROL && reg_wdata[0];
   assign take = tx_valid && tx_ready;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // own tally of accepted frames, restarted with each start request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         eop_seen <= 32'h0000_0000;
      end else if (start_wr) begin
         eop_seen <= 32'h0000_0000;
      end else if (take && tx_word.eop) begin
         eop_seen <= eop_seen + 32'h0000_0001;
      end
   end
   a_word_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
      else $error("word changed while stalled");
   a_no_bubble: assert property (take && !tx_word.eop |=> tx_valid && !tx_word.sop)
      else $error("gap or new frame inside a frame");
   a_frame_gap: assert property (take && tx_word.eop |=> !tx_valid [*2])
      else $error("frames not separated by two idle cycles");
   a_sop_first: assert property ($rose(tx_valid) |-> tx_word.sop)
      else $error("frame begins without start marker");
   a_full_words: assert property (tx_valid && !tx_word.eop |-> tx_word.empty == 3'h0)
      else $error("empty bytes before last word");
   a_read_answer: assert property (reg_read |=> reg_rdata_valid)
      else $error("read not answered next cycle");
   a_answer_cause: assert property (reg_rdata_valid |-> $past(reg_read))
      else $error("read answer without a read");
   a_cfg_reserved: assert property (reg_rdata_valid && $past(reg_addr) ==
      tpg_pkg::OFS_FRAME_CONFIG |-> reg_rdata[31:16] == 16'h0000) else $error("config upper bits");
   a_run_reserved: assert property (reg_rdata_valid && $past(reg_addr) ==
      tpg_pkg::OFS_RUN_CONTROL |-> reg_rdata[31:3] == 29'h0) else $error("run control upper bits");
   a_start_quiet: assert property (start_wr |-> ##2 !tx_valid [*2])
      else $error("stream not restarted on start");
   a_count_match: assert property (reg_rdata_valid && $past(reg_addr) ==
      tpg_pkg::OFS_SENT_FRAME_COUNTER |-> reg_rdata == $past(eop_seen)) else $error("frame count");
   c_frame_done: cover property (take && tx_word.eop);
   c_stall: cover property (tx_valid && !tx_ready);
   c_start: cover property (start_wr);
endmodule : tpg_checker

bind test_packet_generator tpg_checker #(.DATA_BYTES(DATA_BYTES)) chk_u (.clk_sys, .rst_n,
   .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_rdata_valid, .tx_word,
   .tx_valid, .tx_ready);

//--- test/tpg_sink_model.sv
`timescale 1ns/10ps
// stands in for the transmit queue of the MAC
module tpg_sink_model (
   // clock
   input wire logic clk_sys,
   // stream from the generator
   input wire tpg_pkg::tx_word_t tx_word,
   input wire logic tx_valid,
   output logic tx_ready,
   // stall control and capture for the bench
   input wire logic slow,
   output logic [7:0] fb [0:127],
   output int flen,
   output int frames
);
   int idx = 0;
   initial begin
      tx_ready = 1'b0;
      flen = 0;
      frames = 0;
   end
   // slow mode accepts every other cycle to force stalls
   always @(posedge clk_sys) begin
      tx_ready <= slow ? !tx_ready : 1'b1;
   end
   // bytes kept big-endian, only the first 128 of a frame
   always @(posedge clk_sys) begin
      if (tx_valid && tx_ready) begin
         if (tx_word.sop) begin
            idx = 0;
         end
         for (int k = 0; k < 8; k++) begin
            if (idx + k < 128) fb[idx + k] <= tx_word.data[63 - 8 * k -: 8];
         end
         idx = idx + 8;
         if (tx_word.eop) begin
            flen <= idx - int'(tx_word.empty);
            frames <= frames + 1;
         end
      end
   end
endmodule : tpg_sink_model
